/* design/mcc_control.sv */
// mac control word register and the frame steering it drives
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module mcc_control (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // speed and duplex pins
   input wire logic gig_request,
   output logic gig_active,
   output logic half_duplex,
   // receive frame side (from line decoder)
   input wire logic rx_frame_end,
   input wire logic rx_frame_busy,
   input wire logic rx_da_match,
   input wire logic rx_is_pause,
   input wire logic [15:0] rx_pause_quanta,
   input wire logic rx_is_padded,
   output logic rx_deliver,
   output logic rx_strip_fcs,
   output logic rx_strip_pad,
   output logic rx_fifo_flush,
   // transmit frame side
   input wire logic tx_frame_busy,
   input wire logic tx_pause_sent,
   output logic tx_path_run,
   output logic rx_path_run,
   output logic tx_send_pause,
   output logic [15:0] tx_pause_quanta,
   output logic tx_replace_sa,
   output logic [47:0] tx_source_address,
   output logic stats_clear
);
   logic [31:0] ctrl_q;
   logic [47:0] primary_q;
   logic [31:0] supp_q [0:7];
   logic [31:0] frames_ok_q;
   logic xon_pending_q;
   logic stats_clear_q;
   logic rx_flush_q;
   logic gig_request_s;
   logic paused;
   logic pause_load;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic ctrl_wr;
   logic [2:0] sa_sel;
   logic rx_keep;
   logic [31:0] rd_word;
   mcc_pkg::mcc_sr_state_t sr_q;

   function automatic logic is_supp(input logic [11:0] a);
      is_supp = (a >= mcc_pkg::ADDR_SUPP_BASE) && (a <= mcc_pkg::ADDR_SUPP_LAST);
   endfunction

   function automatic logic [2:0] supp_idx(input logic [11:0] a);
      logic [11:0] d;
      d = a - mcc_pkg::ADDR_SUPP_BASE;
      supp_idx = d[4:2];
   endfunction

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == mcc_pkg::ADDR_CONTROL) || (a == mcc_pkg::ADDR_PRIMARY_LO) ||
         (a == mcc_pkg::ADDR_PRIMARY_HI) || is_supp(a) || (a == mcc_pkg::ADDR_STATUS) ||
         (a == mcc_pkg::ADDR_PAUSE_QUANTA) || (a == mcc_pkg::ADDR_FRAMES_OK);
   endfunction

   // ------------------------------------------------------------
   // pin input synchroniser
   // ------------------------------------------------------------
   mcc_sync u_gig_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(gig_request),
      .dout(gig_request_s)
   );

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign pready = 1'b1;
   assign addr_ok = addr_known(paddr) && (paddr[1:0] == 2'b00);
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_en = psel && !penable && !pwrite;
   assign ctrl_wr = wr_en && (paddr == mcc_pkg::ADDR_CONTROL);

   always_comb begin
      rd_word = mcc_pkg::SLVERR_DATA;
      if (paddr == mcc_pkg::ADDR_CONTROL) begin
         rd_word = ctrl_q;
      end else if (paddr == mcc_pkg::ADDR_PRIMARY_LO) begin
         rd_word = primary_q[31:0];
      end else if (paddr == mcc_pkg::ADDR_PRIMARY_HI) begin
         rd_word = {16'h0000, primary_q[47:32]};
      end else if (is_supp(paddr)) begin
         rd_word = supp_q[supp_idx(paddr)];
      end else if (paddr == mcc_pkg::ADDR_STATUS) begin
         rd_word = {27'h0000000, paused, sr_q != mcc_pkg::SR_IDLE, gig_active,
            tx_path_run, rx_path_run};
      end else if (paddr == mcc_pkg::ADDR_PAUSE_QUANTA) begin
         rd_word = {16'h0000, tx_pause_quanta};
      end else if (paddr == mcc_pkg::ADDR_FRAMES_OK) begin
         rd_word = frames_ok_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= mcc_pkg::ZERO_WORD;
      end else if (rd_en) begin
         prdata <= rd_word;
      end
   end

   // ------------------------------------------------------------
   // control word
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= mcc_pkg::CONTROL_RESET;
      end else if (sr_q == mcc_pkg::SR_CLEAN) begin
         ctrl_q[mcc_pkg::BIT_TX_ON] <= 1'b0;
         ctrl_q[mcc_pkg::BIT_RX_ON] <= 1'b0;
         ctrl_q[mcc_pkg::BIT_SOFT_RESET] <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_q <= pwdata & mcc_pkg::CONTROL_RW_MASK;
      end else if (tx_pause_sent && xon_pending_q) begin
         ctrl_q[mcc_pkg::BIT_XON_REQ] <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // address registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_q <= 48'h0000_0000_0000;
      end else if (wr_en && (paddr == mcc_pkg::ADDR_PRIMARY_LO)) begin
         primary_q[31:0] <= pwdata;
      end else if (wr_en && (paddr == mcc_pkg::ADDR_PRIMARY_HI)) begin
         primary_q[47:32] <= pwdata[15:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_supp
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               supp_q[gi] <= mcc_pkg::ZERO_WORD;
            end else if (wr_en && is_supp(paddr) && (supp_idx(paddr) == 3'(gi))) begin
               supp_q[gi] <= pwdata;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // soft reset sequence
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_q <= mcc_pkg::SR_IDLE;
      end else begin
         case (sr_q)
            mcc_pkg::SR_IDLE: begin
               if (ctrl_q[mcc_pkg::BIT_SOFT_RESET]) begin
                  sr_q <= mcc_pkg::SR_DRAIN;
               end
            end
            mcc_pkg::SR_DRAIN: begin
               if (!tx_frame_busy && !rx_frame_busy) begin
                  sr_q <= mcc_pkg::SR_CLEAN;
               end
            end
            mcc_pkg::SR_CLEAN: begin
               sr_q <= mcc_pkg::SR_IDLE;
            end
            default: begin
               sr_q <= mcc_pkg::SR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stats_clear_q <= 1'b0;
      end else begin
         stats_clear_q <= (sr_q == mcc_pkg::SR_CLEAN);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_flush_q <= 1'b0;
      end else begin
         rx_flush_q <= (sr_q == mcc_pkg::SR_CLEAN);
      end
   end
   assign stats_clear = stats_clear_q;
   assign rx_fifo_flush = rx_flush_q;

   // ------------------------------------------------------------
   // speed, duplex, path enables
   // ------------------------------------------------------------
   always_comb begin
      if (ctrl_q[mcc_pkg::BIT_GIG_SEL]) begin
         gig_active = 1'b1;
      end else begin
         gig_active = gig_request_s;
      end
   end

   always_comb begin
      if (ctrl_q[mcc_pkg::BIT_GIG_SEL]) begin
         half_duplex = 1'b0;
      end else begin
         half_duplex = ctrl_q[mcc_pkg::BIT_HALF_DUPLEX];
      end
   end

   assign tx_path_run = ctrl_q[mcc_pkg::BIT_TX_ON] && !paused;
   assign rx_path_run = ctrl_q[mcc_pkg::BIT_RX_ON];

   // ------------------------------------------------------------
   // pause handling
   // ------------------------------------------------------------
   always_comb begin
      pause_load = 1'b0;
      if (rx_frame_end && rx_path_run && rx_is_pause) begin
         pause_load = !ctrl_q[mcc_pkg::BIT_PAUSE_IGNORE];
      end
   end

   mcc_pause_timer u_pause (
      .pclk(pclk),
      .presetn(presetn),
      .load(pause_load),
      .quanta(rx_pause_quanta),
      .paused(paused)
   );

   // request held until the pause frame goes out; a new write wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xon_pending_q <= 1'b0;
      end else if (sr_q == mcc_pkg::SR_CLEAN) begin
         xon_pending_q <= 1'b0;
      end else if (ctrl_wr && pwdata[mcc_pkg::BIT_XON_REQ]) begin
         xon_pending_q <= 1'b1;
      end else if (tx_pause_sent) begin
         xon_pending_q <= 1'b0;
      end
   end
   assign tx_send_pause = xon_pending_q && ctrl_q[mcc_pkg::BIT_TX_ON];
   assign tx_pause_quanta = mcc_pkg::PAUSE_QUANTA_ZERO;

   // ------------------------------------------------------------
   // receive steering
   // ------------------------------------------------------------
   always_comb begin
      rx_keep = 1'b0;
      if (rx_path_run) begin
         if (ctrl_q[mcc_pkg::BIT_ACCEPT_ALL]) begin
            rx_keep = 1'b1;
         end else if (rx_da_match) begin
            rx_keep = 1'b1;
         end
      end
      if (rx_is_pause && !ctrl_q[mcc_pkg::BIT_PASS_PAUSE]) begin
         rx_keep = 1'b0;
      end
   end

   assign rx_deliver = rx_keep;

   always_comb begin
      rx_strip_pad = 1'b0;
      rx_strip_fcs = !ctrl_q[mcc_pkg::BIT_KEEP_FCS];
      if (ctrl_q[mcc_pkg::BIT_PAD_STRIP] && rx_is_padded) begin
         rx_strip_pad = 1'b1;
         rx_strip_fcs = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frames_ok_q <= mcc_pkg::ZERO_WORD;
      end else if (stats_clear_q) begin
         frames_ok_q <= mcc_pkg::ZERO_WORD;
      end else if (rx_frame_end && rx_keep) begin
         frames_ok_q <= frames_ok_q + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------
   // transmit source address
   // ------------------------------------------------------------
   assign sa_sel = ctrl_q[mcc_pkg::BIT_SA_SEL_HI:mcc_pkg::BIT_SA_SEL_LO];
   assign tx_replace_sa = ctrl_q[mcc_pkg::BIT_REPLACE_SA];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_source_address <= 48'h0000_0000_0000;
      end else if (sa_sel[2] == mcc_pkg::SA_SEL_SUPP_FLAG) begin
         tx_source_address <= {supp_q[{sa_sel[1:0], 1'b1}][15:0],
            supp_q[{sa_sel[1:0], 1'b0}]};
      end else begin
         tx_source_address <= primary_q;
      end
   end
endmodule // mcc_control

/* design/mcc_pause_timer.sv */
// pause quanta timer that holds off transmission
`timescale 1ns/1ps
module mcc_pause_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // load request
   input wire logic load,
   input wire logic [15:0] quanta,
   // state
   output logic paused
);
   logic [15:0] quanta_q;
   logic [6:0] sub_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quanta_q <= mcc_pkg::PAUSE_QUANTA_ZERO;
         sub_q <= 7'h00;
      end else if (load) begin
         quanta_q <= quanta;
         sub_q <= 7'h00;
      end else if (quanta_q != mcc_pkg::PAUSE_QUANTA_ZERO) begin
         if (sub_q == mcc_pkg::PAUSE_QUANTUM_CYCLES - 7'h01) begin
            sub_q <= 7'h00;
            quanta_q <= quanta_q - 16'h0001;
         end else begin
            sub_q <= sub_q + 7'h01;
         end
      end
   end

   assign paused = (quanta_q != mcc_pkg::PAUSE_QUANTA_ZERO);
endmodule // mcc_pause_timer

/* design/mcc_pkg.sv */
// package: register map, field positions and states of the mac control word block
package mcc_pkg;
   // register indices (dword offsets) and byte addresses
   localparam logic [7:0] REG_IDX_CONTROL = 8'h02;
   localparam logic [7:0] REG_IDX_PRIMARY_LO = 8'h03;
   localparam logic [7:0] REG_IDX_PRIMARY_HI = 8'h04;
   localparam logic [7:0] REG_IDX_SUPP_BASE = 8'h20;
   localparam logic [7:0] REG_IDX_STATUS = 8'h28;
   localparam logic [7:0] REG_IDX_PAUSE_QUANTA = 8'h29;
   localparam logic [7:0] REG_IDX_FRAMES_OK = 8'h2a;
   localparam logic [11:0] ADDR_CONTROL = 12'h008;
   localparam logic [11:0] ADDR_PRIMARY_LO = 12'h00c;
   localparam logic [11:0] ADDR_PRIMARY_HI = 12'h010;
   localparam logic [11:0] ADDR_SUPP_BASE = 12'h080;
   localparam logic [11:0] ADDR_SUPP_LAST = 12'h09c;
   localparam logic [11:0] ADDR_STATUS = 12'h0a0;
   localparam logic [11:0] ADDR_PAUSE_QUANTA = 12'h0a4;
   localparam logic [11:0] ADDR_FRAMES_OK = 12'h0a8;
   // control word field positions
   localparam int BIT_TX_ON = 0;
   localparam int BIT_RX_ON = 1;
   localparam int BIT_XON_REQ = 2;
   localparam int BIT_GIG_SEL = 3;
   localparam int BIT_ACCEPT_ALL = 4;
   localparam int BIT_PAD_STRIP = 5;
   localparam int BIT_KEEP_FCS = 6;
   localparam int BIT_PASS_PAUSE = 7;
   localparam int BIT_PAUSE_IGNORE = 8;
   localparam int BIT_REPLACE_SA = 9;
   localparam int BIT_HALF_DUPLEX = 10;
   localparam int BIT_SOFT_RESET = 13;
   localparam int BIT_SA_SEL_LO = 16;
   localparam int BIT_SA_SEL_HI = 18;
   // writable field mask, reserved bits read zero
   localparam logic [31:0] CONTROL_RW_MASK = 32'h0007_27ff;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // address select codes
   localparam logic [2:0] SA_SEL_PRIMARY = 3'h0;
   localparam logic SA_SEL_SUPP_FLAG = 1'b1;
   // frame constants
   localparam logic [15:0] PAUSE_QUANTA_ZERO = 16'h0000;
   localparam logic [15:0] PAUSE_QUANTA_RESET = 16'hffff;
   localparam logic [6:0] PAUSE_QUANTUM_CYCLES = 7'h40;
   localparam logic [31:0] SLVERR_DATA = 32'hdead_0bad;

   typedef enum logic [2:0] {
      SR_IDLE = 3'b001,
      SR_DRAIN = 3'b010,
      SR_CLEAN = 3'b100
   } mcc_sr_state_t;
endpackage

/* design/mcc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mcc_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level in and out
   input wire logic din,
   output logic dout
);
   logic meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // mcc_sync

/* testbench/mcc_control_bench.sv */
// bench: register, steering, pause and soft reset tests of the control block
`timescale 1ns/1ps
module mcc_control_bench;
   // ----
   // signals
   // ----
   localparam logic [11:0] CTL = mcc_pkg::ADDR_CONTROL;
   localparam int QC = 2 * mcc_pkg::PAUSE_QUANTUM_CYCLES;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, w;
   logic pready, pslverr, gig_active, half_duplex, rx_deliver, rx_strip_fcs, rx_strip_pad, er;
   logic rx_fifo_flush, tx_path_run, rx_path_run, tx_send_pause, tx_replace_sa, stats_clear;
   logic gig_request = 1'b0, rx_da_match = 1'b0, rx_is_pause = 1'b0, rx_is_padded = 1'b0;
   logic rx_frame_end, rx_frame_busy, tx_frame_busy, tx_pause_sent;
   logic [15:0] rx_pause_quanta = 16'h0, tx_pause_quanta;
   logic [47:0] tx_source_address;
   logic [47:0] addr_tab [5];
   logic [3:0] lat = 4'h0;
   logic [2:0] rxs;
   assign rxs = {rx_deliver, rx_strip_fcs, rx_strip_pad};
   int fail_count = 0, samples_checked = 0, seed = 32'h2e67, i, n, sc = 0;
   always #10 pclk = ~pclk;
   always @(posedge pclk) if (stats_clear === 1'b1) sc <= sc + 1;
   mcc_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .gig_request, .gig_active, .half_duplex, .rx_frame_end, .rx_frame_busy,
      .rx_da_match, .rx_is_pause, .rx_pause_quanta, .rx_is_padded, .rx_deliver, .rx_strip_fcs,
      .rx_strip_pad, .rx_fifo_flush, .tx_frame_busy, .tx_pause_sent, .tx_path_run, .rx_path_run,
      .tx_send_pause, .tx_pause_quanta, .tx_replace_sa, .tx_source_address, .stats_clear);
   mcc_frame_partner u_partner (.pclk, .presetn, .tx_send_pause, .lat, .tx_pause_sent,
      .rx_frame_busy, .rx_frame_end, .tx_frame_busy);
   // ----
   // tasks
   // ----
   task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask
   function automatic logic [2:0] exp_rx(input logic [31:0] c);
      logic pad;
      pad = c[5] & rx_is_padded;
      return {c[1] & (c[4] | rx_da_match) & !(rx_is_pause & !c[7]), !c[6] | pad, pad};
   endfunction
   function automatic logic [11:0] adr(input int k, input int hi);
      if (k == 0) return hi ? mcc_pkg::ADDR_PRIMARY_HI : mcc_pkg::ADDR_PRIMARY_LO;
      return mcc_pkg::ADDR_SUPP_BASE + 12'(8 * k - 8 + 4 * hi);
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(CTL);
      check("ctrl reset", rd, mcc_pkg::CONTROL_RESET);
      for (i = 0; i < 14; i++) begin
         w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0408 : $random(seed);
         w = w & 32'hffff_dffb;
         @(posedge pclk);
         {gig_request, rx_da_match, rx_is_pause, rx_is_padded} <= 4'($random(seed));
         wr(CTL, w);
         rdc(CTL);
         check("ctrl", rd, w & mcc_pkg::CONTROL_RW_MASK);
         settle(2);
         check("duplex", half_duplex, w[10] & !w[3]);
         check("gig", gig_active, w[3] | gig_request);
         check("rx", rxs, exp_rx(w));
         check("paths", {tx_path_run, rx_path_run}, {w[0], w[1]});
         check("sa replace", tx_replace_sa, w[9]);
      end
      rdc(12'h0fc);
      check("unmapped", {er, rd}, {1'b1, mcc_pkg::SLVERR_DATA});
      for (n = 0; n < 5; n++) begin
         addr_tab[n] = {16'($random(seed)), 32'($random(seed))};
         wr(adr(n, 0), addr_tab[n][31:0]);
         wr(adr(n, 1), {16'h0, addr_tab[n][47:32]});
      end
      for (n = 0; n < 5; n++) begin
         wr(CTL, {13'h0, 3'(n == 0 ? 0 : n + 3), 16'h0200});
         settle(2);
         check("source addr", tx_source_address, addr_tab[n]);
      end
      wr(CTL, 32'h0000_0000);
      wr(CTL, 32'h0000_0003);
      rx_is_pause <= 1'b1;
      rx_pause_quanta <= 16'h0002;
      u_partner.rx_frame(4);
      settle(QC - 20);
      check("paused", tx_path_run, 1'b0);
      settle(40);
      check("resumed", tx_path_run, 1'b1);
      wr(CTL, 32'h0000_0103);
      u_partner.rx_frame(4);
      settle(5);
      check("ignored", tx_path_run, 1'b1);
      lat <= 4'h5;
      wr(CTL, 32'h0000_0007);
      @(negedge pclk);
      check("xon", {tx_send_pause, tx_pause_quanta}, {1'b1, 16'h0000});
      settle(12);
      check("xon done", tx_send_pause, 1'b0);
      wr(CTL, 32'h0000_0193);
      u_partner.rx_frame(4);
      rdc(mcc_pkg::ADDR_FRAMES_OK);
      check("frames", rd, 32'h0000_0001);
      @(posedge pclk);
      fork
         u_partner.tx_frame(30);
         begin
            wr(CTL, 32'h0000_2003);
            settle(5);
            check("sr held", sc, 0);
         end
      join
      settle(8);
      check("sr pulse", sc, 1);
      rdc(CTL);
      check("sr ctrl", rd, 32'h0000_0000);
      rdc(mcc_pkg::ADDR_FRAMES_OK);
      check("frames cleared", rd, 32'h0000_0000);
      wr(CTL, 32'h0000_2000);
      settle(8);
      check("sr quiet", sc, 2);
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      tally_and_finish();
   end
endmodule // mcc_control_bench

/* testbench/mcc_control_properties.sv */
// checker: timing relations at the ports of the mac control word block
`timescale 1ns/1ps
module mcc_control_props (
   // clock, reset, apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and frame side
   input wire logic gig_request,
   input wire logic gig_active,
   input wire logic rx_is_padded,
   input wire logic rx_frame_busy,
   input wire logic tx_frame_busy,
   input wire logic tx_pause_sent,
   input wire logic rx_deliver,
   input wire logic rx_strip_fcs,
   input wire logic rx_strip_pad,
   input wire logic rx_fifo_flush,
   input wire logic tx_path_run,
   input wire logic rx_path_run,
   input wire logic tx_send_pause,
   input wire logic [15:0] tx_pause_quanta,
   input wire logic stats_clear
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----
   // sequences and properties
   // ----
   sequence s_wr; psel && penable && pwrite; endsequence
   sequence s_sr_wr; s_wr ##0 (paddr == mcc_pkg::ADDR_CONTROL && pwdata[13]); endsequence
   sequence s_quiet; !rx_frame_busy && !tx_frame_busy; endsequence
   property p_zero_quanta; tx_pause_quanta == 16'h0000; endproperty
   property p_pad_fcs; rx_strip_pad |-> rx_strip_fcs && rx_is_padded; endproperty
   property p_slverr; pslverr |-> psel && penable; endproperty
   property p_ready; pready; endproperty
   property p_deliver; rx_deliver |-> rx_path_run; endproperty
   property p_gig_pin; gig_request [*3] |-> gig_active; endproperty
   property p_xon_done;
      tx_send_pause && tx_pause_sent && !(psel && penable && pwrite) |=> !tx_send_pause;
   endproperty
   property p_sr_done; s_sr_wr ##1 s_quiet [*3] |-> ##[0:3] stats_clear; endproperty
   property p_sr_pulse; stats_clear |-> rx_fifo_flush ##1 !stats_clear; endproperty
   property p_sr_paths; stats_clear |-> !tx_path_run && !rx_path_run; endproperty
   a_zero_quanta: assert property (p_zero_quanta) else $error("pause quanta not zero");
   a_pad_fcs: assert property (p_pad_fcs) else $error("pad strip without fcs strip");
   a_slverr: assert property (p_slverr) else $error("slverr outside access");
   a_ready: assert property (p_ready) else $error("ready low");
   a_deliver: assert property (p_deliver) else $error("delivery with rx off");
   a_gig_pin: assert property (p_gig_pin) else $error("gig request ignored");
   a_xon_done: assert property (p_xon_done) else $error("pause send not cleared");
   a_sr_done: assert property (p_sr_done) else $error("soft reset not done");
   a_sr_pulse: assert property (p_sr_pulse) else $error("clear pulse wrong");
   a_sr_paths: assert property (p_sr_paths) else $error("paths on after reset");
endmodule // mcc_control_props

bind mcc_control mcc_control_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .gig_request, .gig_active, .rx_is_padded, .rx_frame_busy,
   .tx_frame_busy, .tx_pause_sent, .rx_deliver, .rx_strip_fcs, .rx_strip_pad, .rx_fifo_flush,
   .tx_path_run, .rx_path_run, .tx_send_pause, .tx_pause_quanta, .stats_clear);

/* testbench/mcc_frame_partner.sv */
// partner: frame side model, answers pause sends and makes frames
`timescale 1ns/1ps
module mcc_frame_partner (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pause send handshake
   input wire logic tx_send_pause,
   input wire logic [3:0] lat,
   output logic tx_pause_sent,
   // frame activity
   output logic rx_frame_busy,
   output logic rx_frame_end,
   output logic tx_frame_busy
);
   logic [3:0] wait_q;
   initial begin
      rx_frame_busy = 1'b0;
      rx_frame_end = 1'b0;
      tx_frame_busy = 1'b0;
   end
   // one sent pulse after lat cycles of request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 4'h0;
         tx_pause_sent <= 1'b0;
      end else if (tx_send_pause && !tx_pause_sent && wait_q >= lat) begin
         wait_q <= 4'h0;
         tx_pause_sent <= 1'b1;
      end else begin
         wait_q <= tx_send_pause ? wait_q + 4'h1 : 4'h0;
         tx_pause_sent <= 1'b0;
      end
   end
   task automatic rx_frame(input int n);
      rx_frame_busy <= 1'b1;
      repeat (n) @(posedge pclk);
      rx_frame_end <= 1'b1;
      @(posedge pclk);
      rx_frame_busy <= 1'b0;
      rx_frame_end <= 1'b0;
   endtask
   task automatic tx_frame(input int n);
      tx_frame_busy <= 1'b1;
      repeat (n) @(posedge pclk);
      tx_frame_busy <= 1'b0;
   endtask
endmodule // mcc_frame_partner
